// ### hdl/bdc_pkg.sv
// Shared constants for the bidirectional split-enable counter.
package bdc_pkg;

    // ----------------------------------------------------------------
    // Counter geometry and reset values
    // ----------------------------------------------------------------
    localparam int COUNT_WIDTH = 16;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_STEP = 16'h0001;

    // ----------------------------------------------------------------
    // Register byte offsets on the AXI4-Lite slave
    // ----------------------------------------------------------------
    localparam logic [3:0] OFFS_CTRL = 4'h0;
    localparam logic [3:0] OFFS_LOAD_VALUE = 4'h4;
    localparam logic [3:0] OFFS_COUNT = 4'h8;
    localparam logic [3:0] OFFS_STATUS = 4'hC;

    // ----------------------------------------------------------------
    // Control register fields
    // ----------------------------------------------------------------
    localparam int CTRL_UP_BIT = 0;
    localparam int CTRL_DOWN_BIT = 1;
    localparam int CTRL_LOAD_BIT = 2;
    localparam int CTRL_ZERO_BIT = 3;
    localparam logic CTRL_ENABLE_RESET = 1'b0;
    localparam logic [15:0] LOAD_VALUE_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int STAT_ONES_BIT = 0;
    localparam int STAT_ZEROS_BIT = 1;
    localparam int STAT_UPCO_BIT = 2;
    localparam int STAT_DOWNCO_BIT = 3;

    // ----------------------------------------------------------------
    // Bus response codes
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### hdl/bdc_flag_if.sv
// Bundle joining the counter core to its terminal-count decoder.
`timescale 1ns/1ps
interface bdc_flag_if #(
    parameter int WIDTH = 16
);
    logic [WIDTH-1:0] count;
    logic upEn;
    logic downEn;
    logic allOnes;
    logic allZeros;
    logic upCarry;
    logic downCarry;

    // The decoder reads the count and enables and returns the flags.
    modport decoder (
        input count,
        input upEn,
        input downEn,
        output allOnes,
        output allZeros,
        output upCarry,
        output downCarry
    );

    // The counter core drives state and enables and reads the flags.
    modport core (
        output count,
        output upEn,
        output downEn,
        input allOnes,
        input allZeros,
        input upCarry,
        input downCarry
    );
endinterface

// ### hdl/bdc_flag_logic.sv
// Combinational terminal-count and carry decoder.
`timescale 1ns/1ps
module bdc_flag_logic (
    // Count state in, flags out
    bdc_flag_if.decoder flags
);

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------

    // pure gate decode
    // No register here, so a cascade sees the carry in the same cycle.
    always_comb begin
        flags.allOnes = &flags.count;
        flags.allZeros = ~|flags.count;
        flags.upCarry = (&flags.count) & flags.upEn;
        flags.downCarry = (~|flags.count) & flags.downEn;
    end

endmodule

// ### hdl/bdc_counter.sv
// Top of the 16-bit loadable up/down counter with an AXI4-Lite control port.
`timescale 1ns/1ps

// Operation
// - Sixteen-bit count updated on the rising edge; load, zero and count both ways.
// - Clear variant: async clear zeroes count at once, all-ones low, all-zeros high.
// - Reset variant: synchronous reset wins on the edge and zeroes the count.
// - Load enable captures the parallel input on the edge, enables ignored.
// - Up enable increments by one when no zero or load acts.
// - Down enable alone decrements by one when no zero or load acts.
// - Both enables low: value holds and both carry outputs are low.
// - Up carry is high exactly when all bits are one and up enabled.
// - Down carry is high exactly when all bits are zero and down enabled.
// - All-ones flag follows the count alone, whatever the up enable.
// - All-zeros flag follows the count alone, whatever the down enable.
// - Flags and carries are pure gates of count and enables, no register.
// - Master reset starts the count at zero, all-ones low, all-zeros high.
module bdc_counter #(
    parameter bit SYNC_VARIANT = 1'b0,
    parameter int ADDR_WIDTH = 4
) (
    // Clock and master reset
    input wire logic sys_clk,
    input wire logic rst,
    // Counter control pins
    input wire logic asyncZeroInput,
    input wire logic syncZeroInput,
    input wire logic loadEnable,
    input wire logic upCountEnable,
    input wire logic downCountEnable,
    input wire logic [15:0] parallelInput,
    // Counter result pins
    output logic [15:0] countValue,
    output logic allOnesFlag,
    output logic allZerosFlag,
    output logic upCarryOut,
    output logic downCarryOut,
    // AXI4-Lite write address and data
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    bdc_flag_if #(.WIDTH(bdc_pkg::COUNT_WIDTH)) flagBus ();

    logic [15:0] count;
    logic [15:0] next_count;
    logic softUp;
    logic softDown;
    logic softLoadPulse;
    logic softZeroPulse;
    logic [15:0] loadValue;
    logic upEn;
    logic downEn;
    logic loadEn;
    logic [15:0] loadData;
    logic clearActive;
    logic awHeld;
    logic [ADDR_WIDTH-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic doWrite;
    logic readTake;
    logic [31:0] readWord;
    logic readHit;
    logic writeHit;

    // ----------------------------------------------------------------
    // Enables and flag decoder
    // ----------------------------------------------------------------

    // Pin enables and software enables combine, so a cascade still works
    // while software also steers this stage.
    assign upEn = upCountEnable | softUp;
    assign downEn = downCountEnable | softDown;
    assign loadEn = loadEnable | softLoadPulse;
    assign loadData = loadEnable ? parallelInput : loadValue;  // Pin load beats software.
    assign clearActive = ~SYNC_VARIANT & asyncZeroInput;

    // The decoder sees the live count and the combined enables.
    assign flagBus.count = count;
    assign flagBus.upEn = upEn;
    assign flagBus.downEn = downEn;

    bdc_flag_logic u_flags (
        .flags(flagBus.decoder)
    );

    // Flags reach the pins through wires only.
    assign countValue = count;
    assign allOnesFlag = flagBus.allOnes;
    assign allZerosFlag = flagBus.allZeros;
    assign upCarryOut = flagBus.upCarry;
    assign downCarryOut = flagBus.downCarry;

    // ----------------------------------------------------------------
    // Counter next state
    // ----------------------------------------------------------------

    // priority chain
    // Up wins over down when both are raised, which keeps an illegal
    // request deterministic even though the carries then mean nothing.
    always_comb begin
        next_count = count;
        if (rst) begin
            next_count = bdc_pkg::COUNT_RESET;
        end else if (SYNC_VARIANT && syncZeroInput) begin
            next_count = bdc_pkg::COUNT_RESET;
        end else if (softZeroPulse) begin
            next_count = bdc_pkg::COUNT_RESET;
        end else if (loadEn) begin
            next_count = loadData;
        end else if (upEn) begin
            next_count = count + bdc_pkg::COUNT_STEP;
        end else if (downEn) begin
            next_count = count - bdc_pkg::COUNT_STEP;
        end
    end

    // ----------------------------------------------------------------
    // Counter register
    // ----------------------------------------------------------------

    // count register
    // The clear variant needs the clear in the sensitivity list; the
    // reset variant is a plain clocked register.
    generate
        if (SYNC_VARIANT) begin : g_sync
            always_ff @(posedge sys_clk) begin
                count <= next_count;
            end
        end else begin : g_async
            always_ff @(posedge sys_clk or posedge asyncZeroInput) begin
                if (asyncZeroInput) begin
                    count <= bdc_pkg::COUNT_RESET;
                end else begin
                    count <= next_count;
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------

    // Address and data are taken in either order; the write fires once
    // both are held and no response is pending.
    assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
    assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
    assign doWrite = awHeld & wHeld & ~s_axi_bvalid;

    // Write address holding register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            awAddr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    // Write data holding register.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wHeld <= 1'b0;
            wData <= 32'h00000000;
            wStrb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    // All four aligned words are mapped; anything else earns an error.
    always_comb begin
        case (awAddr)
            bdc_pkg::OFFS_CTRL,
            bdc_pkg::OFFS_LOAD_VALUE,
            bdc_pkg::OFFS_COUNT,
            bdc_pkg::OFFS_STATUS: writeHit = 1'b1;
            default: writeHit = 1'b0;
        endcase
    end

    // Write response stands until the master takes it.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= bdc_pkg::RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= writeHit ? bdc_pkg::RESP_OKAY : bdc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Software enables live in the control word and steer the counter.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            softUp <= bdc_pkg::CTRL_ENABLE_RESET;
            softDown <= bdc_pkg::CTRL_ENABLE_RESET;
        end else if (doWrite && awAddr == bdc_pkg::OFFS_CTRL && wStrb[0]) begin
            softUp <= wData[bdc_pkg::CTRL_UP_BIT];
            softDown <= wData[bdc_pkg::CTRL_DOWN_BIT];
        end
    end

    // Load and zero commands are one-cycle strobes that read back as zero.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            softLoadPulse <= 1'b0;
            softZeroPulse <= 1'b0;
        end else begin
            softLoadPulse <= doWrite && awAddr == bdc_pkg::OFFS_CTRL && wStrb[0]
                && wData[bdc_pkg::CTRL_LOAD_BIT];
            softZeroPulse <= doWrite && awAddr == bdc_pkg::OFFS_CTRL && wStrb[0]
                && wData[bdc_pkg::CTRL_ZERO_BIT];
        end
    end

    // Software load value, written byte lane by byte lane.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            loadValue <= bdc_pkg::LOAD_VALUE_RESET;
        end else if (doWrite && awAddr == bdc_pkg::OFFS_LOAD_VALUE) begin
            if (wStrb[0]) begin
                loadValue[7:0] <= wData[7:0];
            end
            if (wStrb[1]) begin
                loadValue[15:8] <= wData[15:8];
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    assign readTake = s_axi_arvalid & s_axi_arready;

    // Read mux; the count and status words show live counter state.
    always_comb begin
        readWord = 32'h00000000;
        readHit = 1'b1;
        case (s_axi_araddr)
            bdc_pkg::OFFS_CTRL: begin
                readWord[bdc_pkg::CTRL_UP_BIT] = softUp;
                readWord[bdc_pkg::CTRL_DOWN_BIT] = softDown;
            end
            bdc_pkg::OFFS_LOAD_VALUE: begin
                readWord[15:0] = loadValue;
            end
            bdc_pkg::OFFS_COUNT: begin
                readWord[15:0] = count;
            end
            bdc_pkg::OFFS_STATUS: begin
                readWord[bdc_pkg::STAT_ONES_BIT] = flagBus.allOnes;
                readWord[bdc_pkg::STAT_ZEROS_BIT] = flagBus.allZeros;
                readWord[bdc_pkg::STAT_UPCO_BIT] = flagBus.upCarry;
                readWord[bdc_pkg::STAT_DOWNCO_BIT] = flagBus.downCarry;
            end
            default: begin
                readHit = 1'b0;
            end
        endcase
    end

    // Read data is captured at the address handshake and held until taken.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= bdc_pkg::RESP_OKAY;
        end else if (readTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= readWord;
            s_axi_rresp <= readHit ? bdc_pkg::RESP_OKAY : bdc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------

    // A plain count step: no zero, no load.
    sequence s_countStep;
        !rst && !(SYNC_VARIANT && syncZeroInput) && !softZeroPulse && !loadEn;
    endsequence

    // A load request with nothing above it in priority.
    sequence s_loadRequest;
        !rst && !(SYNC_VARIANT && syncZeroInput) && !softZeroPulse && loadEn;
    endsequence

    property p_load;
        logic [15:0] d;
        @(posedge sys_clk) disable iff (clearActive)
        (s_loadRequest, d = loadData) |=> (count == d);
    endproperty
    a_load: assert property (p_load) else $error("Load did not capture data.");

    property p_countUp;
        @(posedge sys_clk) disable iff (clearActive)
        s_countStep ##0 upEn |=> (count == $past(count) + bdc_pkg::COUNT_STEP);
    endproperty
    a_countUp: assert property (p_countUp) else $error("Up count missed.");

    property p_countDown;
        @(posedge sys_clk) disable iff (clearActive)
        s_countStep ##0 (downEn && !upEn) |=> (count == $past(count) - bdc_pkg::COUNT_STEP);
    endproperty
    a_countDown: assert property (p_countDown) else $error("Down count missed.");

    property p_hold;
        @(posedge sys_clk) disable iff (clearActive)
        s_countStep ##0 (!upEn && !downEn) |-> (!upCarryOut && !downCarryOut) ##1 $stable(count);
    endproperty
    a_hold: assert property (p_hold) else $error("Idle counter moved or carried.");

    property p_upCarry;
        @(posedge sys_clk) disable iff (rst)
        upCarryOut == ((count == 16'hFFFF) && upEn);
    endproperty
    a_upCarry: assert property (p_upCarry) else $error("Up carry wrong.");

    property p_downCarry;
        @(posedge sys_clk) disable iff (rst)
        downCarryOut == ((count == 16'h0000) && downEn);
    endproperty
    a_downCarry: assert property (p_downCarry) else $error("Down carry wrong.");

    property p_onesFlag;
        @(posedge sys_clk) disable iff (rst)
        allOnesFlag == (count == 16'hFFFF);
    endproperty
    a_onesFlag: assert property (p_onesFlag) else $error("All-ones flag wrong.");

    property p_zerosFlag;
        @(posedge sys_clk) disable iff (rst)
        allZerosFlag == (count == 16'h0000);
    endproperty
    a_zerosFlag: assert property (p_zerosFlag) else $error("All-zeros flag wrong.");

    property p_masterReset;
        @(posedge sys_clk) disable iff (clearActive)
        rst |=> (count == 16'h0000) && allZerosFlag && !allOnesFlag;
    endproperty
    a_masterReset: assert property (p_masterReset) else $error("Master reset not zero.");

    property p_syncReset;
        @(posedge sys_clk) disable iff (rst)
        (SYNC_VARIANT && syncZeroInput) |=> (count == 16'h0000) && allZerosFlag && !allOnesFlag;
    endproperty
    a_syncReset: assert property (p_syncReset) else $error("Sync reset not zero.");

    property p_asyncClear;
        @(posedge sys_clk) disable iff (rst)
        (clearActive && $past(clearActive)) |-> (count == 16'h0000) && allZerosFlag && !allOnesFlag;
    endproperty
    a_asyncClear: assert property (p_asyncClear) else $error("Clear not holding zero.");

    property p_resetOverLoad;
        @(posedge sys_clk) disable iff (clearActive)
        (!rst && SYNC_VARIANT && syncZeroInput && loadEn) |=> (count == 16'h0000);
    endproperty
    a_resetOverLoad: assert property (p_resetOverLoad) else $error("Load beat reset.");

endmodule

// ### sim/bdc_next_stage.sv
// Behavioural next cascade stage with the overall terminal gates.
`timescale 1ns/1ps
module bdc_next_stage (
    // Shared clock, resets and load
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic load,
    input wire logic [15:0] loadData,
    // Carries and flags of the lower stage
    input wire logic upEn,
    input wire logic downEn,
    input wire logic lowOnes,
    input wire logic lowZeros,
    // Upper stage state and overall terminals
    output logic [15:0] upperCount,
    output logic overallOnes,
    output logic overallZeros
);
    always_ff @(posedge sys_clk or posedge clr) begin
        if (clr) begin
            upperCount <= 16'h0000;
        end else if (rst) begin
            upperCount <= 16'h0000;
        end else if (load) begin
            upperCount <= loadData;
        end else if (upEn) begin
            upperCount <= upperCount + 16'h0001;
        end else if (downEn) begin
            upperCount <= upperCount - 16'h0001;
        end
    end

    assign overallOnes = lowOnes && (upperCount == 16'hFFFF);
    assign overallZeros = lowZeros && (upperCount == 16'h0000);
endmodule

// ### sim/tb.sv
// Self-checking bench: clear and reset variants side by side.
`timescale 1ns/1ps
module tb;
    logic sys_clk, rst, asyncZeroInput, syncZeroInput, loadEnable, upCountEnable, downCountEnable;
    logic [15:0] parallelInput, countValue, count2, upperCount, expCount, expUpper;
    logic allOnesFlag, allZerosFlag, upCarryOut, downCarryOut, overallOnes, overallZeros;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata, busData;
    logic [1:0] s_axi_bresp, s_axi_rresp, busResp;
    int failures = 0;
    int samples_checked = 0;
    // Both variants see the same stimulus, so any split shows the variant logic.
    bdc_counter #(.SYNC_VARIANT(1'b0), .ADDR_WIDTH(4)) DUT (.sys_clk, .rst, .asyncZeroInput, .syncZeroInput,
        .loadEnable, .upCountEnable, .downCountEnable, .parallelInput, .countValue, .allOnesFlag, .allZerosFlag,
        .upCarryOut, .downCarryOut, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    bdc_counter #(.SYNC_VARIANT(1'b1), .ADDR_WIDTH(4)) DUT2 (.sys_clk, .rst, .asyncZeroInput, .syncZeroInput,
        .loadEnable, .upCountEnable, .downCountEnable, .parallelInput, .countValue(count2), .allOnesFlag(),
        .allZerosFlag(), .upCarryOut(), .downCarryOut(), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(),
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready);
    bdc_next_stage PARTNER (.sys_clk, .rst, .clr(asyncZeroInput), .load(loadEnable), .loadData(parallelInput),
        .upEn(upCarryOut), .downEn(downCarryOut), .lowOnes(allOnesFlag), .lowZeros(allZerosFlag), .upperCount,
        .overallOnes, .overallZeros);

    // Free-running 50 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic complete_run();
        if (failures == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Pins change after an edge; flags are judged at the falling edge, the count one cycle on.
    task automatic step(input logic u, input logic d, input logic l, input logic [15:0] v, input logic [3:0] m);
        logic ones, zeros;
        @(posedge sys_clk);
        upCountEnable <= u;
        downCountEnable <= d;
        loadEnable <= l;
        parallelInput <= v;
        @(negedge sys_clk);
        ones = (expCount == 16'hFFFF);
        zeros = (expCount == 16'h0000);
        chk("count", 32'(expCount), 32'(countValue));
        chk("countSync", 32'(expCount), 32'(count2));
        chk("flags", 32'({zeros && d, ones && u, zeros, ones} & m),
            32'({downCarryOut, upCarryOut, allZerosFlag, allOnesFlag} & m));
        chk("upper", 32'(expUpper), 32'(upperCount));
        chk("overall", 32'({ones && expUpper == 16'hFFFF, zeros && expUpper == 16'h0000}),
            32'({overallOnes, overallZeros}));
        expUpper = l ? v : (u && ones) ? expUpper + 16'h0001 : (d && zeros) ? expUpper - 16'h0001 : expUpper;
        expCount = l ? v : u ? expCount + 16'h0001 : d ? expCount - 16'h0001 : expCount;
    endtask

    task automatic realign(input logic [15:0] v);
        @(posedge sys_clk);
        loadEnable <= 1'b1;
        parallelInput <= v;
        @(posedge sys_clk);
        loadEnable <= 1'b0;
        expCount = v;
        expUpper = v;
    endtask

    // Each channel is held until its ready is seen at the falling edge before the taking edge.
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
        logic awTaken, wTaken, done;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(negedge sys_clk);
            awTaken = s_axi_awvalid && s_axi_awready;
            wTaken = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            busResp = s_axi_bresp;
            @(posedge sys_clk);
            if (awTaken) s_axi_awvalid <= 1'b0;
            if (wTaken) s_axi_wvalid <= 1'b0;
            if (done) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
        chk("bresp", 32'(bdc_pkg::RESP_OKAY), 32'(busResp));
    endtask

    task automatic axi_read(input logic [3:0] a, input logic [31:0] e);
        logic arTaken, done;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(negedge sys_clk);
            arTaken = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            busData = s_axi_rdata;
            busResp = s_axi_rresp;
            @(posedge sys_clk);
            if (arTaken) s_axi_arvalid <= 1'b0;
            if (done) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
        chk("rresp", 32'(bdc_pkg::RESP_OKAY), 32'(busResp));
        chk("rdata", e, busData);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_bus();
        axi_read(bdc_pkg::OFFS_CTRL, 32'h0);
        axi_read(bdc_pkg::OFFS_LOAD_VALUE, 32'h0);
        axi_write(bdc_pkg::OFFS_LOAD_VALUE, 32'h00005A5A);
        axi_read(bdc_pkg::OFFS_LOAD_VALUE, 32'h00005A5A);
        axi_write(bdc_pkg::OFFS_CTRL, 32'h4);
        axi_read(bdc_pkg::OFFS_COUNT, 32'h00005A5A);
        axi_read(bdc_pkg::OFFS_CTRL, 32'h0);
        axi_write(bdc_pkg::OFFS_CTRL, 32'h2);
        axi_read(bdc_pkg::OFFS_CTRL, 32'h2);
        axi_write(bdc_pkg::OFFS_CTRL, 32'h8);
        axi_read(bdc_pkg::OFFS_STATUS, 32'h2);
        axi_write(bdc_pkg::OFFS_COUNT, 32'h00001111);
        axi_read(bdc_pkg::OFFS_COUNT, 32'h0);
    endtask

    task automatic test_counting();
        step(1'b0, 1'b0, 1'b0, 16'h0000, 4'hF);
        step(1'b1, 1'b0, 1'b1, 16'hFFFE, 4'hF);
        step(1'b1, 1'b0, 1'b0, 16'h0000, 4'hF);
        step(1'b1, 1'b0, 1'b0, 16'h0000, 4'hF);
        step(1'b0, 1'b1, 1'b0, 16'h0000, 4'hF);
        step(1'b0, 1'b0, 1'b0, 16'h0000, 4'hF);
        step(1'b0, 1'b1, 1'b0, 16'h0000, 4'hF);
        step(1'b1, 1'b1, 1'b0, 16'h0000, 4'h3);
        step(1'b0, 1'b0, 1'b1, 16'h0000, 4'hF);
        step(1'b0, 1'b0, 1'b0, 16'h0000, 4'hF);
    endtask

    task automatic test_async();
        realign(16'h1234);
        @(posedge sys_clk);
        asyncZeroInput <= 1'b1;
        loadEnable <= 1'b1;
        parallelInput <= 16'h00FF;
        #5;
        chk("clearCount", 32'h0, 32'(countValue));
        chk("clearFlags", 32'h2, 32'({allZerosFlag, allOnesFlag}));
        chk("syncKeeps", 32'h1234, 32'(count2));
        @(posedge sys_clk);
        loadEnable <= 1'b0;
        @(negedge sys_clk);
        chk("clearWins", 32'h0, 32'(countValue));
        chk("syncLoads", 32'h00FF, 32'(count2));
        @(posedge sys_clk);
        asyncZeroInput <= 1'b0;
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        expCount = 16'h0000;
        expUpper = 16'h0000;
        step(1'b0, 1'b0, 1'b0, 16'h0000, 4'hF);
    endtask

    task automatic test_sync();
        realign(16'h4321);
        @(posedge sys_clk);
        syncZeroInput <= 1'b1;
        loadEnable <= 1'b1;
        parallelInput <= 16'h0F0F;
        @(negedge sys_clk);
        chk("syncWaits", 32'h4321, 32'(count2));
        @(posedge sys_clk);
        syncZeroInput <= 1'b0;
        loadEnable <= 1'b0;
        @(negedge sys_clk);
        chk("syncZero", 32'h0, 32'(count2));
        chk("clearVarLoads", 32'h0F0F, 32'(countValue));
        realign(16'h0000);
        step(1'b0, 1'b0, 1'b0, 16'h0000, 4'hF);
    endtask

    // Main sequence: five reset cycles, then every scenario in turn.
    initial begin
        rst = 1'b1;
        {asyncZeroInput, syncZeroInput, loadEnable, upCountEnable, downCountEnable} = 5'h00;
        {parallelInput, expCount, expUpper} = 48'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        test_bus();
        test_counting();
        test_async();
        test_sync();
        complete_run();
    end

    // Watchdog: the scenarios need under a hundred cycles, so this only trips on a hang.
    initial begin
        #100000;
        failures++;
        complete_run();
    end
endmodule
